// ===== hw/pmic_top_event_flags.sv
// Top-level latched event flags, protective actions and register access
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Power-ok output falling latches a flag, held until one is written.
// - Read-only summary bit is set while any regulator event is pending.
// - Latch external clock event when the sync clock appears or disappears.
// - Thermal shutdown latches a flag, stops regulators, pulls outputs low.
// - No regulator is enabled while the thermal shutdown flag is set.
// - Thermal warning latches a flag; a live bit tracks the condition.
// - Input overvoltage latches a flag, stops regulators, pulls outputs low.
// - Live overvoltage condition is a separate read-only status bit.
// - Bit 0 latches when a load current measurement result is ready.
// - Analog supply undervoltage or software restart sets the reset flag.
// - Restart stops regulators, restores defaults, reruns startup.
// - Reserved bit 6 reads zero; all event flags reset to zero.
module pmic_top_event_flags
  import top_event_pkg::*;
#(
  parameter int unsigned STARTUP_LEN = top_event_pkg::STARTUP_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Register access port
  input wire logic [top_event_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [top_event_pkg::DATA_W-1:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [top_event_pkg::DATA_W-1:0] o_reg_rdata,
  // Monitored conditions
  input wire logic i_power_ok_output,
  input wire logic i_sync_clk_present,
  input wire logic i_thermal_shutdown_live,
  input wire logic i_thermal_warning_live,
  input wire logic i_input_overvoltage_live,
  input wire logic i_meas_result_ready,
  input wire logic [top_event_pkg::DATA_W-1:0] i_regulator_events,
  input wire logic i_analog_supply_uv,
  input wire logic i_software_restart,
  // Regulator and general output control
  input wire logic [top_event_pkg::NUM_REGULATORS-1:0] i_regulator_en_req,
  input wire logic i_general_output_a_req,
  input wire logic i_general_output_b_req,
  output logic [top_event_pkg::NUM_REGULATORS-1:0] o_regulator_en,
  output logic o_general_output_a,
  output logic o_general_output_b,
  output logic o_startup_active
);
  import top_event_pkg::*;

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  if (STARTUP_LEN < 1) begin : g_bad_startup
    $error("STARTUP_LEN must be at least one cycle");
  end

  // Restart masks assume the reset event flag is the top flag
  if (FL_RST != NUM_FLAGS - 1) begin : g_bad_flag_order
    $error("reset event flag must be the top flag of the bank");
  end

  // Every field position must fit inside one register word
  if (DATA_W <= BIT_POWER_OK_LOSS) begin : g_bad_data_w
    $error("DATA_W too narrow for the event fields");
  end

  localparam int unsigned CNT_W =
    (STARTUP_LEN > 1) ? $clog2(STARTUP_LEN + 1) : 1;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(STARTUP_LEN);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_RESTART = 3'b001,
    SEQ_STARTUP = 3'b010,
    SEQ_RUN = 3'b100
  } seq_e;

  typedef struct packed {
    seq_e seq;
    logic [CNT_W-1:0] cnt;
    logic prev_pok;
    logic prev_sync;
    logic prev_tsd;
    logic prev_warn;
    logic prev_ovp;
    logic [NUM_REGULATORS-1:0] prev_req;
    logic [NUM_REGULATORS-1:0] reg_en;
    logic gpo_a;
    logic gpo_b;
    logic startup;
    logic [DATA_W-1:0] rdata;
  } state_s;

  state_s state;
  state_s next_state;

  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic [NUM_FLAGS-1:0] flags;
  logic [DATA_W-1:0] reg_a_view;
  logic [DATA_W-1:0] reg_b_view;
  logic [DATA_W-1:0] live_view;
  logic restart_req;
  logic restarting;
  logic fault_event;
  logic wr_a;
  logic wr_b;

  // ---------------------------------------------------------------
  // Event detection
  // ---------------------------------------------------------------
  // Restart source: supply undervoltage or software request
  assign restart_req = i_analog_supply_uv | i_software_restart;
  assign restarting = restart_req | (state.seq == SEQ_RESTART);
  assign wr_a = i_reg_wr & (i_reg_addr == ADDR_TOP_EVENT_FLAGS_A);
  assign wr_b = i_reg_wr & (i_reg_addr == ADDR_TOP_EVENT_FLAGS_B);

  // Hardware set terms for each latched flag
  always_comb begin
    flag_set = '0;
    flag_set[FL_POK] = state.prev_pok & ~i_power_ok_output;
    flag_set[FL_SYNC] = state.prev_sync ^ i_sync_clk_present;
    flag_set[FL_TSD] = ~state.prev_tsd & i_thermal_shutdown_live;
    flag_set[FL_WARN] = ~state.prev_warn & i_thermal_warning_live;
    flag_set[FL_OVP] = ~state.prev_ovp & i_input_overvoltage_live;
    flag_set[FL_MEAS] = i_meas_result_ready;
    flag_set[FL_RST] = restart_req;
    if (restarting) begin
      flag_set[FL_RST-1:0] = '0;
    end
  end

  // Write-one clears; a restart returns the other flags to default
  always_comb begin
    flag_clr = '0;
    if (wr_a) begin
      flag_clr[FL_POK] = i_reg_wdata[BIT_POWER_OK_LOSS];
      flag_clr[FL_SYNC] = i_reg_wdata[BIT_EXT_CLOCK];
      flag_clr[FL_TSD] = i_reg_wdata[BIT_THERMAL_SD];
      flag_clr[FL_WARN] = i_reg_wdata[BIT_THERMAL_WARN];
      flag_clr[FL_OVP] = i_reg_wdata[BIT_OVERVOLTAGE];
      flag_clr[FL_MEAS] = i_reg_wdata[BIT_MEAS_DONE];
    end
    if (wr_b) begin
      flag_clr[FL_RST] = i_reg_wdata[BIT_RESET_EVENT];
    end
    if (restarting) begin
      flag_clr[FL_RST-1:0] = '1;
    end
  end

  event_flag_bank #(
    .WIDTH(NUM_FLAGS)
  ) u_flags (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_set(flag_set),
    .i_clr(flag_clr),
    .o_flag(flags)
  );

  // Shutdown or overvoltage arriving this cycle
  assign fault_event = flag_set[FL_TSD] | flag_set[FL_OVP];

  // ---------------------------------------------------------------
  // Register views
  // ---------------------------------------------------------------
  always_comb begin
    reg_a_view = READ_ZERO;
    reg_a_view[BIT_POWER_OK_LOSS] = flags[FL_POK];
    reg_a_view[BIT_RESERVED_A6] = 1'b0;
    reg_a_view[BIT_REG_SUMMARY] = |i_regulator_events;
    reg_a_view[BIT_EXT_CLOCK] = flags[FL_SYNC];
    reg_a_view[BIT_THERMAL_SD] = flags[FL_TSD];
    reg_a_view[BIT_THERMAL_WARN] = flags[FL_WARN];
    reg_a_view[BIT_OVERVOLTAGE] = flags[FL_OVP];
    reg_a_view[BIT_MEAS_DONE] = flags[FL_MEAS];
    reg_b_view = READ_ZERO;
    reg_b_view[BIT_RESET_EVENT] = flags[FL_RST];
  end

  // Live conditions, kept apart from the latched flags
  always_comb begin
    live_view = READ_ZERO;
    live_view[BIT_LIVE_POWER_OK] = i_power_ok_output;
    live_view[BIT_LIVE_EXT_CLOCK] = ~i_sync_clk_present;
    live_view[BIT_LIVE_THERMAL_SD] = i_thermal_shutdown_live;
    live_view[BIT_LIVE_THERMAL_WARN] = i_thermal_warning_live;
    live_view[BIT_LIVE_OVERVOLTAGE] = i_input_overvoltage_live;
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.prev_pok = i_power_ok_output;
    next_state.prev_sync = i_sync_clk_present;
    next_state.prev_tsd = i_thermal_shutdown_live;
    next_state.prev_warn = i_thermal_warning_live;
    next_state.prev_ovp = i_input_overvoltage_live;
    next_state.prev_req = i_regulator_en_req;

    // Restart and startup sequencing
    case (state.seq)
      SEQ_RESTART: begin
        if (!restart_req) begin
          next_state.seq = SEQ_STARTUP;
          next_state.cnt = CNT_LOAD;
        end
      end
      SEQ_STARTUP: begin
        if (restart_req) begin
          next_state.seq = SEQ_RESTART;
        end else if (state.cnt == CNT_ONE) begin
          next_state.seq = SEQ_RUN;
          next_state.cnt = '0;
        end else begin
          next_state.cnt = state.cnt - CNT_ONE;
        end
      end
      SEQ_RUN: begin
        if (restart_req) begin
          next_state.seq = SEQ_RESTART;
        end
      end
      default: begin
        next_state.seq = SEQ_RESTART;
      end
    endcase
    next_state.startup = (next_state.seq != SEQ_RUN);

    // Regulator enables: turn on at a request edge, off when dropped
    next_state.reg_en = (state.reg_en | (i_regulator_en_req & ~state.prev_req))
      & i_regulator_en_req;
    if (flags[FL_TSD]) begin
      next_state.reg_en = state.reg_en & i_regulator_en_req;
    end
    if (fault_event) begin
      next_state.reg_en = '0;
    end
    if (restarting || next_state.seq != SEQ_RUN) begin
      next_state.reg_en = '0;
    end

    // General outputs held low while a protective fault is latched
    if (fault_event || flags[FL_TSD] || flags[FL_OVP] || restarting) begin
      next_state.gpo_a = 1'b0;
      next_state.gpo_b = 1'b0;
    end else begin
      next_state.gpo_a = i_general_output_a_req;
      next_state.gpo_b = i_general_output_b_req;
    end

    // Read data, zero for unmapped addresses
    if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_TOP_EVENT_FLAGS_A: next_state.rdata = reg_a_view;
        ADDR_TOP_EVENT_FLAGS_B: next_state.rdata = reg_b_view;
        ADDR_TOP_LIVE_STATUS: next_state.rdata = live_view;
        default: next_state.rdata = READ_ZERO;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state.seq <= SEQ_RESTART;
      state.cnt <= '0;
      state.prev_pok <= 1'b0;
      state.prev_sync <= 1'b0;
      state.prev_tsd <= 1'b0;
      state.prev_warn <= 1'b0;
      state.prev_ovp <= 1'b0;
      state.prev_req <= '0;
      state.reg_en <= '0;
      state.gpo_a <= 1'b0;
      state.gpo_b <= 1'b0;
      state.startup <= 1'b1;
      state.rdata <= READ_ZERO;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flip-flops
  assign o_reg_rdata = state.rdata;
  assign o_regulator_en = state.reg_en;
  assign o_general_output_a = state.gpo_a;
  assign o_general_output_b = state.gpo_b;
  assign o_startup_active = state.startup;

endmodule // pmic_top_event_flags

`default_nettype wire

// ===== hw/top_event_pkg.sv
// Constants shared by the top-level event flag block
package top_event_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam logic [7:0] ADDR_TOP_EVENT_FLAGS_A = 8'h19;
  localparam logic [7:0] ADDR_TOP_EVENT_FLAGS_B = 8'h1a;
  localparam logic [7:0] ADDR_TOP_LIVE_STATUS = 8'h1d;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ---------------------------------------------------------------
  // Field positions of top_event_flags_a
  // ---------------------------------------------------------------
  localparam int unsigned BIT_POWER_OK_LOSS = 7;
  localparam int unsigned BIT_RESERVED_A6 = 6;
  localparam int unsigned BIT_REG_SUMMARY = 5;
  localparam int unsigned BIT_EXT_CLOCK = 4;
  localparam int unsigned BIT_THERMAL_SD = 3;
  localparam int unsigned BIT_THERMAL_WARN = 2;
  localparam int unsigned BIT_OVERVOLTAGE = 1;
  localparam int unsigned BIT_MEAS_DONE = 0;

  // Field position of top_event_flags_b
  localparam int unsigned BIT_RESET_EVENT = 0;

  // Field positions of the live status register
  localparam int unsigned BIT_LIVE_POWER_OK = 7;
  localparam int unsigned BIT_LIVE_EXT_CLOCK = 4;
  localparam int unsigned BIT_LIVE_THERMAL_SD = 3;
  localparam int unsigned BIT_LIVE_THERMAL_WARN = 2;
  localparam int unsigned BIT_LIVE_OVERVOLTAGE = 1;

  // ---------------------------------------------------------------
  // Latched flag bank layout
  // ---------------------------------------------------------------
  localparam int unsigned NUM_FLAGS = 7;
  localparam int unsigned FL_MEAS = 0;
  localparam int unsigned FL_OVP = 1;
  localparam int unsigned FL_WARN = 2;
  localparam int unsigned FL_TSD = 3;
  localparam int unsigned FL_SYNC = 4;
  localparam int unsigned FL_POK = 5;
  localparam int unsigned FL_RST = 6;
  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 7'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned STARTUP_TIME_NS = 1000;
  localparam int unsigned STARTUP_CYCLES =
    (STARTUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned NUM_REGULATORS = 2;

endpackage

// ===== hw/event_flag_bank.sv
// Bank of sticky event flags, set by hardware and cleared by writing one
`timescale 1ns/1ps
`default_nettype none

module event_flag_bank #(
  parameter int unsigned WIDTH = 7
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_set,
  input wire logic [WIDTH-1:0] i_clr,
  output logic [WIDTH-1:0] o_flag
);

  typedef struct packed {
    logic [WIDTH-1:0] flag;
  } state_s;

  state_s state;
  state_s next_state;

  // Width check
  if (WIDTH < 1) begin : g_bad_width
    $error("event_flag_bank needs at least one flag");
  end

  // ---------------------------------------------------------------
  // Per-flag update: set has priority over clear
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    for (int unsigned k = 0; k < WIDTH; k++) begin
      next_state.flag[k] = i_set[k] | (state.flag[k] & ~i_clr[k]);
    end
  end

  // Register stage, all flags clear at reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state.flag <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign o_flag = state.flag;

endmodule // event_flag_bank

`default_nettype wire

// ===== dv/top_event_props.sv
// Port assertions for the top-level event flag block
`timescale 1ns/1ps
`default_nettype none
module top_event_props
  import top_event_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [top_event_pkg::ADDR_W-1:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [top_event_pkg::DATA_W-1:0] o_reg_rdata,
  input wire logic i_thermal_shutdown_live,
  input wire logic i_thermal_warning_live,
  input wire logic i_input_overvoltage_live,
  input wire logic [top_event_pkg::DATA_W-1:0] i_regulator_events,
  input wire logic i_analog_supply_uv,
  input wire logic i_software_restart,
  input wire logic [top_event_pkg::NUM_REGULATORS-1:0] o_regulator_en,
  input wire logic o_general_output_a,
  input wire logic o_general_output_b,
  input wire logic o_startup_active
);
  // ---------------------------------------------
  // Properties
  // ---------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_tsd_shutoff: assert property (
    $rose(i_thermal_shutdown_live) |=> o_regulator_en == 2'b00
    && !o_general_output_a && !o_general_output_b)
    else $error("thermal shutdown left outputs on");
  chk_ovp_shutoff: assert property (
    $rose(i_input_overvoltage_live) |=> o_regulator_en == 2'b00
    && !o_general_output_a && !o_general_output_b)
    else $error("overvoltage left outputs on");
  chk_tsd_refuse: assert property (
    $rose(i_thermal_shutdown_live) ##1 (!i_reg_wr) [*8]
    |=> o_regulator_en == 2'b00)
    else $error("regulator enabled while shutdown flag set");
  chk_restart_off: assert property (
    i_software_restart || i_analog_supply_uv
    |=> o_regulator_en == 2'b00 && o_startup_active)
    else $error("restart did not stop regulators");
  chk_reserved_a: assert property (
    i_reg_rd && i_reg_addr == ADDR_TOP_EVENT_FLAGS_A
    |=> o_reg_rdata[6] == 1'b0)
    else $error("reserved bit 6 not zero");
  chk_reserved_b: assert property (
    i_reg_rd && i_reg_addr == ADDR_TOP_EVENT_FLAGS_B
    |=> o_reg_rdata[7:1] == 7'h00)
    else $error("reserved upper bits not zero");
  chk_summary_bit: assert property (
    i_reg_rd && i_reg_addr == ADDR_TOP_EVENT_FLAGS_A
    |=> o_reg_rdata[5] == |$past(i_regulator_events))
    else $error("summary bit wrong");
  chk_live_status: assert property (
    i_reg_rd && i_reg_addr == ADDR_TOP_LIVE_STATUS
    |=> o_reg_rdata[3:1] == {$past(i_thermal_shutdown_live),
    $past(i_thermal_warning_live), $past(i_input_overvoltage_live)})
    else $error("live status bits wrong");
endmodule // top_event_props
bind pmic_top_event_flags top_event_props i_props (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
  .i_thermal_shutdown_live(i_thermal_shutdown_live),
  .i_thermal_warning_live(i_thermal_warning_live),
  .i_input_overvoltage_live(i_input_overvoltage_live),
  .i_regulator_events(i_regulator_events),
  .i_analog_supply_uv(i_analog_supply_uv),
  .i_software_restart(i_software_restart),
  .o_regulator_en(o_regulator_en), .o_general_output_a(o_general_output_a),
  .o_general_output_b(o_general_output_b),
  .o_startup_active(o_startup_active));
`default_nettype wire

// ===== dv/event_host_model.sv
// Host side model: register reads, writes and restart requests
`timescale 1ns/1ps
`default_nettype none
module event_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  output logic o_restart
);
  // Idle bus at time zero
  initial begin
    o_addr = 8'h00;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_restart = 1'b0;
  end
  // One-cycle write; released lines show inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = v;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~v;
  endtask
  // One-cycle read; data taken after the sampling edge
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    v = i_rdata;
  endtask
  // Restart bit written, then cleared again
  task automatic restart;
    @(negedge i_clk);
    o_restart = 1'b1;
    @(negedge i_clk);
    o_restart = 1'b0;
  endtask
endmodule // event_host_model
`default_nettype wire

// ===== dv/pmic_top_event_flags_tb.sv
// Self-checking testbench for the top-level event flag block
`timescale 1ns/1ps
`default_nettype none
module pmic_top_event_flags_tb;
  import top_event_pkg::*;
  logic i_clk, i_rst_n, wr, rd, uv, sw, ga_req, gb_req, ga, gb, start;
  logic [7:0] addr, wdata, rdata, events, cond, d;
  logic [1:0] en_req, en;
  int failures, total_checks, b, s;
  int bits[6] = '{0, 1, 2, 3, 4, 7};
  pmic_top_event_flags #(.STARTUP_LEN(4)) i_dut (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_power_ok_output(~cond[7]), .i_sync_clk_present(cond[4]),
    .i_thermal_shutdown_live(cond[3]), .i_thermal_warning_live(cond[2]),
    .i_input_overvoltage_live(cond[1]), .i_meas_result_ready(cond[0]),
    .i_regulator_events(events), .i_analog_supply_uv(uv),
    .i_software_restart(sw), .i_regulator_en_req(en_req),
    .i_general_output_a_req(ga_req), .i_general_output_b_req(gb_req),
    .o_regulator_en(en), .o_general_output_a(ga),
    .o_general_output_b(gb), .o_startup_active(start));
  event_host_model i_host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .o_restart(sw));
  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
    i_host.rd(a, d);
    check(d, exp);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic wait_start;
    for (int n = 0; n < 100 && start !== 1'b0; n++) cyc(1);
    check({7'h00, start}, 8'h00);
  endtask
  function automatic logic [7:0] live_exp(input logic [7:0] c);
    return {~c[7], 2'b00, ~c[4], c[3:1], 1'b0};
  endfunction
  task automatic end_of_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Watchdog
  initial begin
    #100000;
    failures++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test;
  end
  // ---------------------------------------------
  // Tests
  // ---------------------------------------------
  initial begin
    {cond, events, en_req, ga_req, gb_req, uv, i_rst_n} = '0;
    s = $urandom(32'h83ce5657);
    cyc(20);
    i_rst_n = 1'b1;
    check_reg(ADDR_TOP_EVENT_FLAGS_A, 8'h00);
    check_reg(ADDR_TOP_EVENT_FLAGS_B, 8'h00);
    check_reg(8'h20 + 8'($urandom_range(0, 200)), 8'h00);
    wait_start;
    $display("test reset done");
    foreach (bits[k]) begin
      b = bits[k];
      en_req = 2'b00;
      ga_req = 1'($urandom);
      gb_req = 1'($urandom);
      cyc(2);
      en_req = 2'($urandom_range(1, 3));
      cyc(3);
      check({4'h0, en, ga, gb}, {4'h0, en_req, ga_req, gb_req});
      cond[b] = 1'b1;
      cyc(6);
      if (b == 1 || b == 3) check({4'h0, en, ga, gb}, 8'h00);
      if (b == 3) begin
        en_req = 2'b00;
        cyc(2);
        en_req = 2'b11;
        cyc(2);
        check({6'h00, en}, 8'h00);
      end
      check_reg(ADDR_TOP_LIVE_STATUS, live_exp(cond));
      cond[b] = 1'b0;
      cyc(2);
      check_reg(ADDR_TOP_EVENT_FLAGS_A, 8'h01 << b);
      i_host.wr(ADDR_TOP_EVENT_FLAGS_A, ~(8'h01 << b));
      check_reg(ADDR_TOP_EVENT_FLAGS_A, 8'h01 << b);
      i_host.wr(ADDR_TOP_EVENT_FLAGS_A, 8'h01 << b);
      check_reg(ADDR_TOP_EVENT_FLAGS_A, 8'h00);
    end
    $display("test event flags done");
    events = 8'($urandom_range(1, 255));
    i_host.wr(ADDR_TOP_EVENT_FLAGS_A, 8'hff);
    check_reg(ADDR_TOP_EVENT_FLAGS_A, 8'h20);
    events = 8'h00;
    check_reg(ADDR_TOP_EVENT_FLAGS_A, 8'h00);
    // Loss of the sync clock alone must set the flag again
    cond[4] = 1'b1;
    cyc(2);
    i_host.wr(ADDR_TOP_EVENT_FLAGS_A, 8'h10);
    cond[4] = 1'b0;
    cyc(2);
    check_reg(ADDR_TOP_EVENT_FLAGS_A, 8'h10);
    i_host.wr(ADDR_TOP_EVENT_FLAGS_A, 8'h10);
    // Event lands in the very cycle of its clearing write
    fork
      i_host.wr(ADDR_TOP_EVENT_FLAGS_A, 8'h01);
      begin
        cyc(1);
        cond[0] = 1'b1;
        cyc(1);
        cond[0] = 1'b0;
      end
    join
    check_reg(ADDR_TOP_EVENT_FLAGS_A, 8'h01);
    $display("test summary and set-wins done");
    cond[2] = 1'b1;
    cyc(2);
    cond[2] = 1'b0;
    i_host.restart();
    check({start, 5'h00, en}, 8'h80);
    check_reg(ADDR_TOP_EVENT_FLAGS_B, 8'h01);
    check_reg(ADDR_TOP_EVENT_FLAGS_A, 8'h00);
    wait_start;
    i_host.wr(ADDR_TOP_EVENT_FLAGS_B, 8'h00);
    check_reg(ADDR_TOP_EVENT_FLAGS_B, 8'h01);
    i_host.wr(ADDR_TOP_EVENT_FLAGS_B, 8'hff);
    check_reg(ADDR_TOP_EVENT_FLAGS_B, 8'h00);
    uv = 1'b1;
    cyc(3);
    uv = 1'b0;
    check_reg(ADDR_TOP_EVENT_FLAGS_B, 8'h01);
    wait_start;
    $display("test restart done");
    end_of_test;
  end
endmodule // pmic_top_event_flags_tb
`default_nettype wire
